// ==== design/dsc_loader.sv ====
`timescale 1ns/10ps
// What this block does
// - Shift serial input on clock rise while selected.
// - Serial output advances on each selected clock rise.
// - Select rising stops shifting, runs command nibble.
// - Plain frame is exactly 24 bits long.
// - Narrow variants ignore lowest data bits.
// - 32-bit shift register drives serial output.
// - Commands 0..2 load hold, transfer, both.
// - Commands 8..D load both and set range.
// - Command F and reserved codes change nothing.
// - Data word is last 16 bits shifted.
// - Zero pin resets every register immediately.
// - Reset gives 0-5V range and zero code.
// - Transfer after clear keeps output at zero.
// - Range changes only with a load of both words.
module dsc_loader
  import dsc_pkg::*;
(
  input  wire logic        I_SYS_CLK,
  input  wire logic        I_RSTN,
  input  wire logic        I_ASYNC_ZERO_N,
  input  wire logic        I_SERIAL_CLK,
  input  wire logic        I_SELECT_LOAD_N,
  input  wire logic        I_SERIAL_IN,
  input  wire logic        I_APPLY_READY,
  output logic             O_SERIAL_OUT,
  output logic             O_LOAD_READY,
  output logic             O_CMD_PENDING,
  output logic [15:0]      O_INPUT_HOLD,
  output logic [15:0]      O_DAC_WORD,
  output logic [2:0]       O_RANGE
);

  // ---------------------------------------------------------------
  // Reset and clear
  // ---------------------------------------------------------------
  // The zero pin joins the reset tree so it acts without the clock.
  // Its release is not synchronised; a release near a clock edge can
  // leave one register a cycle behind, which is harmless at zero code.
  logic rst_n;

  assign rst_n = I_RSTN & I_ASYNC_ZERO_N;

  // ---------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------
  logic [SYNC_W-1:0] pins_s;
  logic              sck_s;
  logic              sel_n_s;
  logic              sdi_s;
  logic              sck_prev_q;
  logic              sck_prev_d;
  logic              sel_prev_q;
  logic              sel_prev_d;
  logic              sck_rise;
  logic              load_pulse;

  dsc_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (rst_n),
    .i_d     ({I_SERIAL_CLK, I_SELECT_LOAD_N, I_SERIAL_IN}),
    .o_q     (pins_s)
  );

  assign sck_s   = pins_s[2];
  assign sel_n_s = pins_s[1];
  assign sdi_s   = pins_s[0];

  assign sck_rise   = sck_s && !sck_prev_q;
  assign load_pulse = sel_n_s && !sel_prev_q;

  always_comb begin
    sck_prev_d = sck_s;
    sel_prev_d = sel_n_s;
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sck_prev_q <= SYNC_RST[2];
      sel_prev_q <= SYNC_RST[1];
    end else begin
      sck_prev_q <= sck_prev_d;
      sel_prev_q <= sel_prev_d;
    end
  end

  // ---------------------------------------------------------------
  // Input shift register
  // ---------------------------------------------------------------
  logic [SR_W-1:0] shift_q;
  logic [SR_W-1:0] shift_d;

  always_comb begin
    shift_d = shift_q;
    if (!sel_n_s && sck_rise) begin
      shift_d = {shift_q[SR_W-2:0], sdi_s};
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      shift_q <= SR_RST;
    end else begin
      shift_q <= shift_d;
    end
  end

  // The top stage is a flop, so the output moves with each shift.
  assign O_SERIAL_OUT = shift_q[SR_W-1];

  // ---------------------------------------------------------------
  // Command queue
  // ---------------------------------------------------------------
  // Frames that arrive faster than the output side applies them wait
  // here; a load while the queue is full is dropped, and the host can
  // watch the load-ready output to avoid that.
  dsc_stream_if #(.W(ENTRY_W)) frame_in ();
  dsc_stream_if #(.W(ENTRY_W)) frame_out ();

  // A 24-bit frame and the tail of a 32-bit frame share one layout.
  assign frame_in.valid = load_pulse;
  assign frame_in.data  = {shift_q[CMD_HI:CMD_LO],
                           shift_q[DATA_W-1:0] & DATA_MASK};
  assign frame_out.ready = I_APPLY_READY;

  dsc_fifo #(
    .W     (ENTRY_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (I_SYS_CLK),
    .i_rst_n (rst_n),
    .s_in    (frame_in),
    .s_out   (frame_out)
  );

  assign O_LOAD_READY  = frame_in.ready;
  assign O_CMD_PENDING = frame_out.valid;

  // ---------------------------------------------------------------
  // Command execution
  // ---------------------------------------------------------------
  logic [15:0] hold_q;
  logic [15:0] hold_d;
  logic [15:0] code_q;
  logic [15:0] code_d;
  dsc_range_e  range_q;
  dsc_range_e  range_d;
  logic [3:0]  cmd;
  logic [15:0] word;
  logic        take;

  assign take = frame_out.valid && frame_out.ready;
  assign cmd  = frame_out.data[ENTRY_W-1:DATA_W];
  assign word = frame_out.data[DATA_W-1:0];

  always_comb begin
    hold_d  = hold_q;
    code_d  = code_q;
    range_d = range_q;
    if (take) begin
      unique case (cmd)
        CMD_LOAD_HOLD: begin
          hold_d = word;
        end
        CMD_XFER: begin
          code_d = hold_q;
        end
        CMD_LOAD_BOTH: begin
          hold_d = word;
          code_d = word;
        end
        CMD_RNG_U5, CMD_RNG_U10, CMD_RNG_B5,
        CMD_RNG_B10, CMD_RNG_B2P5, CMD_RNG_OFS: begin
          hold_d  = word;
          code_d  = word;
          range_d = dsc_range_e'(cmd[2:0]);
        end
        default: begin
          // No operation and reserved codes leave all state alone.
          hold_d = hold_q;
        end
      endcase
    end
  end

  always_ff @(posedge I_SYS_CLK or negedge rst_n) begin
    if (!rst_n) begin
      hold_q  <= WORD_RST;
      code_q  <= WORD_RST;
      range_q <= RANGE_RST;
    end else begin
      hold_q  <= hold_d;
      code_q  <= code_d;
      range_q <= range_d;
    end
  end

  assign O_INPUT_HOLD = hold_q;
  assign O_DAC_WORD   = code_q;
  assign O_RANGE      = range_q;

endmodule

// ==== design/dsc_pkg.sv ====
package dsc_pkg;

  // ---------------------------------------------------------------
  // Frame layout
  // ---------------------------------------------------------------
  localparam int          SR_W      = 32;
  localparam int          CMD_HI    = 23;
  localparam int          CMD_LO    = 20;
  localparam int          CMD_W     = 4;
  localparam int          DATA_W    = 16;
  localparam int          ENTRY_W   = CMD_W + DATA_W;

  // Resolution of the converter: 16, 14 or 12 bits.
  localparam int          RES_BITS  = 16;
  localparam logic [15:0] DATA_MASK =
    16'(16'hFFFF << (DATA_W - RES_BITS));

  // ---------------------------------------------------------------
  // Buffering and synchroniser
  // ---------------------------------------------------------------
  localparam int          FIFO_DEPTH = 16;
  localparam int          SYNC_W     = 3;
  // Bit 1 is the select/load pin, idle high.
  localparam logic [2:0]  SYNC_RST   = 3'h2;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] SR_RST     = 32'h0000_0000;
  localparam logic [15:0] WORD_RST   = 16'h0000;

  // ---------------------------------------------------------------
  // Commands and ranges
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_LOAD_HOLD  = 4'h0,
    CMD_XFER       = 4'h1,
    CMD_LOAD_BOTH  = 4'h2,
    CMD_RNG_U5     = 4'h8,
    CMD_RNG_U10    = 4'h9,
    CMD_RNG_B5     = 4'hA,
    CMD_RNG_B10    = 4'hB,
    CMD_RNG_B2P5   = 4'hC,
    CMD_RNG_OFS    = 4'hD,
    CMD_NOP        = 4'hF
  } dsc_cmd_e;

  typedef enum logic [2:0] {
    RNG_U5   = 3'h0,
    RNG_U10  = 3'h1,
    RNG_B5   = 3'h2,
    RNG_B10  = 3'h3,
    RNG_B2P5 = 3'h4,
    RNG_OFS  = 3'h5
  } dsc_range_e;

  localparam dsc_range_e RANGE_RST = RNG_U5;

endpackage

// ==== design/dsc_stream_if.sv ====
`timescale 1ns/10ps
interface dsc_stream_if #(
  parameter int W = 20
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface

// ==== design/dsc_sync.sv ====
`timescale 1ns/10ps
module dsc_sync #(
  parameter int           W       = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  // ---------------------------------------------------------------
  // Two-flop synchroniser; only the second stage leaves the module.
  // ---------------------------------------------------------------
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= RST_VAL;
      sync_q <= RST_VAL;
    end else begin
      meta_q <= i_d;
      sync_q <= meta_q;
    end
  end

  assign o_q = sync_q;

endmodule

// ==== design/dsc_fifo.sv ====
`timescale 1ns/10ps
module dsc_fifo #(
  parameter int W     = 20,
  parameter int DEPTH = 16
) (
  input  wire logic   i_clk,
  input  wire logic   i_rst_n,
  dsc_stream_if.sink   s_in,
  dsc_stream_if.source s_out
);

  localparam int AW = $clog2(DEPTH);

  // ---------------------------------------------------------------
  // Storage and pointers
  // ---------------------------------------------------------------
  logic [W-1:0] mem_q [DEPTH];
  logic [W-1:0] mem_d [DEPTH];
  logic [AW:0]  wr_q;
  logic [AW:0]  wr_d;
  logic [AW:0]  rd_q;
  logic [AW:0]  rd_d;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // The extra pointer bit tells a full ring from an empty one.
  assign empty = (wr_q == rd_q);
  assign full  = (wr_q[AW] != rd_q[AW]) &&
                 (wr_q[AW-1:0] == rd_q[AW-1:0]);
  assign push  = s_in.valid && !full;
  assign pop   = s_out.ready && !empty;

  assign s_in.ready  = !full;
  assign s_out.valid = !empty;
  assign s_out.data  = mem_q[rd_q[AW-1:0]];

  always_comb begin
    mem_d = mem_q;
    wr_d  = wr_q;
    rd_d  = rd_q;
    if (push) begin
      mem_d[wr_q[AW-1:0]] = s_in.data;
      wr_d                = wr_q + 1'b1;
    end
    if (pop) begin
      rd_d = rd_q + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      mem_q <= '{default: '0};
      wr_q  <= '0;
      rd_q  <= '0;
    end else begin
      mem_q <= mem_d;
      wr_q  <= wr_d;
      rd_q  <= rd_d;
    end
  end

endmodule

// ==== testbench/dsc_loader_sva.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------
// Port checker
// ----------------------------------------------------------
module dsc_loader_sva (
  input wire logic        I_SYS_CLK,
  input wire logic        I_RSTN,
  input wire logic        I_ASYNC_ZERO_N,
  input wire logic        I_SERIAL_CLK,
  input wire logic        I_SELECT_LOAD_N,
  input wire logic        I_SERIAL_IN,
  input wire logic        I_APPLY_READY,
  input wire logic        O_SERIAL_OUT,
  input wire logic        O_LOAD_READY,
  input wire logic        O_CMD_PENDING,
  input wire logic [15:0] O_INPUT_HOLD,
  input wire logic [15:0] O_DAC_WORD,
  input wire logic [2:0]  O_RANGE
);
  default clocking cb @(posedge I_SYS_CLK);
  endclocking
  // Clear acts as a reset, so most checks pause while it is low.
  default disable iff (!I_RSTN || !I_ASYNC_ZERO_N);
  sequence s_load;
    $rose(I_SELECT_LOAD_N) ##2 O_LOAD_READY;
  endsequence
  a_clear_zero: assert property (disable iff (!I_RSTN)
    !I_ASYNC_ZERO_N |-> O_DAC_WORD == 0 && O_INPUT_HOLD == 0)
    else $error("clear left a buffer loaded");
  a_clear_flush: assert property (disable iff (!I_RSTN)
    !I_ASYNC_ZERO_N |-> !O_CMD_PENDING && !O_SERIAL_OUT && O_RANGE == 0)
    else $error("clear left queue, shift or range");
  a_shift_cause: assert property (
    $changed(O_SERIAL_OUT) |->
      $past(I_SERIAL_CLK, 3) && !$past(I_SELECT_LOAD_N, 3))
    else $error("serial output moved without a selected clock rise");
  a_idle_still: assert property (
    I_SELECT_LOAD_N [*4] |-> $stable(O_SERIAL_OUT))
    else $error("serial output moved while deselected");
  a_load_exec: assert property (s_load |-> ##[1:2] O_CMD_PENDING)
    else $error("load edge did not queue a command");
  a_out_cause: assert property (
    $changed({O_DAC_WORD, O_INPUT_HOLD, O_RANGE}) |->
      $past(O_CMD_PENDING) && $past(I_APPLY_READY))
    else $error("outputs changed with nothing executed");
  a_range_both: assert property (
    $changed(O_RANGE) |-> O_DAC_WORD == O_INPUT_HOLD)
    else $error("range changed without loading both buffers");
  a_xfer_copy: assert property (
    $changed(O_DAC_WORD) && $stable(O_INPUT_HOLD) |->
      O_DAC_WORD == $past(O_INPUT_HOLD))
    else $error("code buffer took a value not from the hold buffer");
  a_full_pend: assert property (!O_LOAD_READY |-> O_CMD_PENDING)
    else $error("queue full yet nothing pending");
endmodule

// ==== testbench/dsc_host_model.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------
// Host link model
// ----------------------------------------------------------
module dsc_host_model (
  input  wire logic        i_sout,
  output logic             o_sck,
  output logic             o_csn,
  output logic             o_sdi,
  output logic [31:0]      o_cap
);
  initial begin
    o_sck = 1'b0;
    o_csn = 1'b1;
    o_sdi = 1'b0;
    o_cap = 32'h0000_0000;
  end
  // Clock stands low between frames; data is inverted once released so
  // a stale bit cannot pass for a driven one.
  task automatic send(input logic [31:0] f, input int n);
    o_csn = 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      o_sdi = f[i];
      #62.5;
      o_cap = {o_cap[30:0], i_sout};
      o_sck = 1'b1;
      #62.5;
      o_sck = 1'b0;
    end
    #62.5;
    o_csn = 1'b1;
    o_sdi = ~o_sdi;
    #400;
  endtask
endmodule

// ==== testbench/tb_top.sv ====
`timescale 1ns/10ps
// ----------------------------------------------------------
// Bench
// ----------------------------------------------------------
module tb_top
  import dsc_pkg::*;
;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        zero_n = 1'b1;
  logic        apply = 1'b1;
  logic        sck;
  logic        csn;
  logic        serial_in;
  logic        sout;
  logic        lrdy;
  logic        pend;
  logic [15:0] hold;
  logic [15:0] dac;
  logic [2:0]  rng;
  logic [31:0] cap;
  int          err_total = 0;
  int          compares = 0;

  always #5 clk = ~clk;

  dsc_loader u_dsc_loader (
    .I_SYS_CLK(clk), .I_RSTN(rstn), .I_ASYNC_ZERO_N(zero_n),
    .I_SERIAL_CLK(sck), .I_SELECT_LOAD_N(csn), .I_SERIAL_IN(serial_in),
    .I_APPLY_READY(apply), .O_SERIAL_OUT(sout), .O_LOAD_READY(lrdy),
    .O_CMD_PENDING(pend), .O_INPUT_HOLD(hold), .O_DAC_WORD(dac),
    .O_RANGE(rng));
  dsc_host_model u_dsc_host_model (
    .i_sout(sout), .o_sck(sck), .o_csn(csn), .o_sdi(serial_in), .o_cap(cap));

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task automatic results();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic idle();
    int k;
    k = 0;
    while (pend !== 1'b0 && k < 100) begin
      @(posedge clk);
      #1;
      k++;
    end
    if (pend !== 1'b0) begin
      chk(32'h0, 32'h1);
      results();
    end
  endtask
  task automatic put(input logic [3:0] c, input logic [15:0] d);
    u_dsc_host_model.send({8'h00, c, 4'h0, d}, 24);
    idle();
  endtask
  task automatic t_ranges();
    logic [15:0] d;
    for (int c = 8; c < 14; c++) begin
      d = 16'(c * 32'h1357);
      put(4'(c), d);
      chk(rng, 32'(c - 8));
      chk(dac, d & DATA_MASK);
      chk(hold, d & DATA_MASK);
    end
    $display("test ranges done");
  endtask
  task automatic t_basic();
    logic [51:0] r [7];
    r = '{52'h2_A5A5_A5A5_A5A5, 52'h0_1234_1234_A5A5,
          52'h3_FFFF_1234_A5A5, 52'h7_FFFF_1234_A5A5,
          52'hE_FFFF_1234_A5A5, 52'hF_FFFF_1234_A5A5,
          52'h1_0000_1234_1234};
    foreach (r[i]) begin
      put(r[i][51:48], r[i][47:32]);
      chk(hold, r[i][31:16] & DATA_MASK);
      chk(dac, r[i][15:0] & DATA_MASK);
      chk(rng, 32'h5);
    end
    $display("test commands done");
  endtask
  task automatic t_chain();
    u_dsc_host_model.send(32'hA520_1357, 32);
    idle();
    chk(dac, 16'h1357 & DATA_MASK);
    u_dsc_host_model.send(32'h00F0_0000, 32);
    idle();
    chk(cap, 32'hA520_1357);
    chk(dac, 16'h1357 & DATA_MASK);
    $display("test chain done");
  endtask
  task automatic t_clear();
    put(4'hB, 16'h5555);
    @(posedge clk);
    #1 zero_n = 1'b0;
    repeat (2) @(posedge clk);
    chk({dac, hold}, 32'h0);
    chk({rng, sout}, 32'h0);
    #1 zero_n = 1'b1;
    put(4'h1, 16'h7777);
    chk(dac, 32'h0);
    fork
      u_dsc_host_model.send(32'h0090_BEEF, 24);
      begin
        repeat (100) @(posedge clk);
        #1 zero_n = 1'b0;
        repeat (2) @(posedge clk);
        #1 zero_n = 1'b1;
      end
    join
    idle();
    chk(hold, 16'hBEEF & DATA_MASK);
    chk({dac, rng}, 32'h0);
    put(4'hA, 16'h0000);
    chk(rng, 32'h2);
    $display("test clear done");
  endtask
  task automatic t_stall();
    @(posedge clk);
    #1 apply = 1'b0;
    for (int i = 0; i < 17; i++) begin
      u_dsc_host_model.send(32'h0020_0000 + i * 32'h1111, 24);
    end
    chk({lrdy, pend}, 32'h1);
    chk(dac, 32'h0);
    @(posedge clk);
    #1 apply = 1'b1;
    idle();
    chk(dac, 16'hFFFF & DATA_MASK);
    chk(lrdy, 32'h1);
    $display("test stall done");
  endtask

  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk({dac, hold}, 32'h0);
    chk({rng, lrdy, pend}, 32'h2);
    $display("test reset done");
    t_ranges();
    t_basic();
    t_chain();
    t_clear();
    t_stall();
    results();
  end
endmodule

bind dsc_loader dsc_loader_sva u_dsc_loader_sva (
  .I_SYS_CLK(I_SYS_CLK), .I_RSTN(I_RSTN), .I_ASYNC_ZERO_N(I_ASYNC_ZERO_N),
  .I_SERIAL_CLK(I_SERIAL_CLK), .I_SELECT_LOAD_N(I_SELECT_LOAD_N),
  .I_SERIAL_IN(I_SERIAL_IN), .I_APPLY_READY(I_APPLY_READY),
  .O_SERIAL_OUT(O_SERIAL_OUT), .O_LOAD_READY(O_LOAD_READY),
  .O_CMD_PENDING(O_CMD_PENDING), .O_INPUT_HOLD(O_INPUT_HOLD),
  .O_DAC_WORD(O_DAC_WORD), .O_RANGE(O_RANGE));
